/* File: src/csc_pkg.sv */
package csc_pkg;

   // --------------------------------------------------------------
   // coprocessor move selector
   // --------------------------------------------------------------
   typedef struct packed {
      logic [2:0] opc1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] opc2;
   } csc_sel_s;

   localparam csc_sel_s SEL_GEOM_ID  = '{opc1: 3'h1, crn: 4'h0, crm: 4'h0, opc2: 3'h0};
   localparam csc_sel_s SEL_LEVEL_ID = '{opc1: 3'h1, crn: 4'h0, crm: 4'h0, opc2: 3'h1};
   localparam csc_sel_s SEL_AUX_ID   = '{opc1: 3'h1, crn: 4'h0, crm: 4'h0, opc2: 3'h7};
   localparam csc_sel_s SEL_GEOM_SEL = '{opc1: 3'h2, crn: 4'h0, crm: 4'h0, opc2: 3'h0};
   localparam csc_sel_s SEL_SYS_CTL  = '{opc1: 3'h0, crn: 4'h1, crm: 4'h0, opc2: 3'h0};

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        priv;
      csc_sel_s    sel;
      logic [31:0] wdata;
   } csc_req_s;

   // --------------------------------------------------------------
   // strap inputs, index in the strap vector
   // --------------------------------------------------------------
   localparam int STRAP_N       = 5;
   localparam int STRAP_IENDIAN = 0;
   localparam int STRAP_ISET    = 1;
   localparam int STRAP_EENDIAN = 2;
   localparam int STRAP_NMFIQ   = 3;
   localparam int STRAP_HIVEC   = 4;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // --------------------------------------------------------------
   // cache geometry fields
   // --------------------------------------------------------------
   localparam logic [3:0]  GEOM_CAPS      = 4'hf;
   localparam logic [9:0]  GEOM_WAYS_M1   = 10'h003;
   localparam logic [2:0]  GEOM_LINE_CODE = 3'h1;
   localparam int          GEOM_SETS_PER_KB = 8;
   localparam logic [2:0]  LEVEL_TWO      = 3'h1;
   localparam logic [2:0]  LEVEL_ONE      = 3'h0;

   // --------------------------------------------------------------
   // system control bit positions and fixed values
   // --------------------------------------------------------------
   localparam int SC_IENDIAN = 31;
   localparam int SC_ISET    = 30;
   localparam int SC_NMFIQ   = 27;
   localparam int SC_EENDIAN = 25;
   localparam int SC_VECIRQ  = 24;
   localparam int SC_DIVZ    = 19;
   localparam int SC_BGREG   = 17;
   localparam int SC_REPL    = 14;
   localparam int SC_HIVEC   = 13;
   localparam int SC_ICACHE  = 12;
   localparam int SC_SWAP    = 10;
   localparam int SC_DCACHE  = 2;
   localparam int SC_ALIGN   = 1;
   localparam int SC_MPU     = 0;
   localparam logic [31:0] SC_ONES = 32'h00e5_0878;

   localparam logic [31:0] VEC_LOW_BASE  = 32'h0000_0000;
   localparam logic [31:0] VEC_HIGH_BASE = 32'hffff_0000;
   localparam logic [31:0] VEC_IRQ_OFS   = 32'h0000_0018;

endpackage

/* File: src/csc_regs.sv */
`timescale 1ns/1ps
// Function
// - geometry low field gives log2 of words per line minus two
// - geometry reports sets minus one and ways minus one
// - geometry top four capability bits read as one; whole geometry word reads zero for an absent cache
// - geometry value follows configured cache size, sets doubling per step
// - select bit zero chooses instruction (1) or data (0) cache geometry
// - select level field reads zero, writes ignored, upper bits ignored
// - unification and coherency levels one if any cache, shareable field zero
// - outer level fields and unified bit read zero
// - level bits one and zero show data and instruction caches present
// - auxiliary id always reads zero
// - user mode access is undefined; privileged mode only
// - control bit 31 shows instruction endianness from its strap
// - exception set, exception endianness, vector location load straps at reset
// - control bit 27 read-only, follows unmaskable fast interrupt strap
// - bit 24 selects fixed irq vector or external controller address
// - bit 19 traps divide by zero when set
// - bit 14 stored, replacement always random
// - bit 13 places vectors low or high
// - bits 12 and 2 enable caches, zero if cache absent
// - bit 10 enables locked swap instructions, else undefined
// - bit 1 alignment checking, bit 0 protection unit, zero if absent
// - fixed control bits read as one or zero
module csc_regs #(
   parameter int unsigned P_ICACHE_KB = 16,
   parameter int unsigned P_DCACHE_KB = 16,
   parameter bit          P_HAS_MPU   = 1'b1
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_reset_n,
   input  wire csc_pkg::csc_req_s i_req,
   output logic                   o_req_ready,
   output logic                   o_resp_valid,
   output logic                   o_resp_undef,
   output logic [31:0]            o_rdata,
   input  wire logic              i_instr_endian_strap,
   input  wire logic              i_exc_iset_strap,
   input  wire logic              i_exc_endian_strap,
   input  wire logic              i_unmaskable_fast_irq_strap,
   input  wire logic              i_high_vector_strap,
   output logic                   o_instr_endian,
   output logic                   o_exc_iset,
   output logic                   o_exc_endian,
   output logic                   o_unmaskable_fast_irq,
   output logic                   o_vectored_irq_select,
   output logic                   o_div_zero_trap,
   output logic                   o_bg_region_en,
   output logic                   o_replacement_policy_bit,
   output logic                   o_replace_random,
   output logic                   o_high_vector_base,
   output logic                   o_icache_en,
   output logic                   o_dcache_en,
   output logic                   o_swap_instr_enable,
   output logic                   o_align_check,
   output logic                   o_mpu_en,
   output logic [31:0]            o_vector_base,
   output logic [31:0]            o_irq_vector_addr
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [csc_pkg::STRAP_N-1:0] strap_meta;
      logic [csc_pkg::STRAP_N-1:0] strap_sync;
      logic [1:0]                  settle_cnt;
      logic                        straps_done;
      logic                        sel_instr;
      logic                        exc_iset;
      logic                        exc_endian;
      logic                        vec_irq;
      logic                        div_zero;
      logic                        bg_region;
      logic                        repl;
      logic                        high_vec;
      logic                        icache;
      logic                        swap;
      logic                        dcache;
      logic                        align;
      logic                        mpu;
      logic                        resp_valid;
      logic                        resp_undef;
      logic [31:0]                 rdata;
   } csc_state_s;

   localparam bit HAS_IC  = (P_ICACHE_KB != 0);
   localparam bit HAS_DC  = (P_DCACHE_KB != 0);
   localparam bit HAS_ANY = HAS_IC || HAS_DC;

   csc_state_s q;
   csc_state_s d;
   logic       take;

   // ---------------------------------------------------------------
   // read value builders
   // ---------------------------------------------------------------
   // line code
   function automatic logic [31:0] geom_word(input int unsigned kb);
      logic [14:0] sets_m1;
      sets_m1 = 15'(kb * csc_pkg::GEOM_SETS_PER_KB - 1);
      if (kb == 0) begin
         geom_word = '0;
      end else begin
         geom_word = {csc_pkg::GEOM_CAPS, sets_m1, csc_pkg::GEOM_WAYS_M1, csc_pkg::GEOM_LINE_CODE};
      end
   endfunction

   function automatic logic [31:0] level_word();
      logic [2:0] lvl;
      lvl = HAS_ANY ? csc_pkg::LEVEL_TWO : csc_pkg::LEVEL_ONE;
      level_word = {2'h0, lvl, lvl, 3'h0, 18'h0, 1'b0, HAS_DC, HAS_IC};
   endfunction

   function automatic logic [31:0] sysctl_word(input csc_state_s s);
      logic [31:0] v;
      v = csc_pkg::SC_ONES;
      v[csc_pkg::SC_IENDIAN] = s.strap_sync[csc_pkg::STRAP_IENDIAN];
      v[csc_pkg::SC_ISET]    = s.exc_iset;
      v[csc_pkg::SC_NMFIQ]   = s.strap_sync[csc_pkg::STRAP_NMFIQ];
      v[csc_pkg::SC_EENDIAN] = s.exc_endian;
      v[csc_pkg::SC_VECIRQ]  = s.vec_irq;
      v[csc_pkg::SC_DIVZ]    = s.div_zero;
      v[csc_pkg::SC_BGREG]   = s.bg_region;
      v[csc_pkg::SC_REPL]    = s.repl;
      v[csc_pkg::SC_HIVEC]   = s.high_vec;
      v[csc_pkg::SC_ICACHE]  = s.icache;
      v[csc_pkg::SC_SWAP]    = s.swap;
      v[csc_pkg::SC_DCACHE]  = s.dcache;
      v[csc_pkg::SC_ALIGN]   = s.align;
      v[csc_pkg::SC_MPU]     = s.mpu;
      sysctl_word = v;
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   assign o_req_ready = q.straps_done;
   assign take        = i_req.valid && q.straps_done;

   always_comb begin
      d            = q;
      d.strap_meta = {i_high_vector_strap, i_unmaskable_fast_irq_strap, i_exc_endian_strap,
                      i_exc_iset_strap, i_instr_endian_strap};
      d.strap_sync = q.strap_meta;
      d.resp_valid = take;
      d.resp_undef = 1'b0;
      if (q.settle_cnt != csc_pkg::STRAP_SETTLE) begin
         d.settle_cnt = q.settle_cnt + 2'h1;
      end
      // strap load
      // waits for the synchroniser to fill so no metastable value is latched
      if (q.settle_cnt == csc_pkg::STRAP_SETTLE && !q.straps_done) begin
         d.straps_done = 1'b1;
         d.exc_iset    = q.strap_sync[csc_pkg::STRAP_ISET];
         d.exc_endian  = q.strap_sync[csc_pkg::STRAP_EENDIAN];
         d.high_vec    = q.strap_sync[csc_pkg::STRAP_HIVEC];
      end
      if (take) begin
         d.rdata = '0;
         if (!i_req.priv) begin
            d.resp_undef = 1'b1;
         end else begin
            unique case (i_req.sel)
               csc_pkg::SEL_GEOM_ID: begin
                  if (!i_req.write) begin
                     d.rdata = q.sel_instr ? geom_word(P_ICACHE_KB) : geom_word(P_DCACHE_KB);
                  end
               end
               csc_pkg::SEL_LEVEL_ID: begin
                  if (!i_req.write) begin
                     d.rdata = level_word();
                  end
               end
               csc_pkg::SEL_AUX_ID: begin
                  d.rdata = '0;
               end
               csc_pkg::SEL_GEOM_SEL: begin
                  if (i_req.write) begin
                     d.sel_instr = i_req.wdata[0];
                  end else begin
                     d.rdata = {31'h0, q.sel_instr};
                  end
               end
               csc_pkg::SEL_SYS_CTL: begin
                  if (i_req.write) begin
                     d.exc_iset   = i_req.wdata[csc_pkg::SC_ISET];
                     d.exc_endian = i_req.wdata[csc_pkg::SC_EENDIAN];
                     d.vec_irq    = i_req.wdata[csc_pkg::SC_VECIRQ];
                     d.div_zero   = i_req.wdata[csc_pkg::SC_DIVZ];
                     d.bg_region  = i_req.wdata[csc_pkg::SC_BGREG];
                     d.repl       = i_req.wdata[csc_pkg::SC_REPL];
                     d.high_vec   = i_req.wdata[csc_pkg::SC_HIVEC];
                     d.icache     = HAS_IC && i_req.wdata[csc_pkg::SC_ICACHE];
                     d.dcache     = HAS_DC && i_req.wdata[csc_pkg::SC_DCACHE];
                     d.swap       = i_req.wdata[csc_pkg::SC_SWAP];
                     d.align      = i_req.wdata[csc_pkg::SC_ALIGN];
                     d.mpu        = P_HAS_MPU && i_req.wdata[csc_pkg::SC_MPU];
                  end else begin
                     d.rdata = sysctl_word(q);
                  end
               end
               default: begin
                  // selectors outside this group are not ours to answer
                  d.resp_undef = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_resp_valid             = q.resp_valid;
   assign o_resp_undef             = q.resp_undef;
   assign o_rdata                  = q.rdata;
   assign o_instr_endian           = q.strap_sync[csc_pkg::STRAP_IENDIAN];
   assign o_unmaskable_fast_irq    = q.strap_sync[csc_pkg::STRAP_NMFIQ];
   assign o_exc_iset               = q.exc_iset;
   assign o_exc_endian             = q.exc_endian;
   assign o_vectored_irq_select    = q.vec_irq;
   assign o_div_zero_trap          = q.div_zero;
   assign o_bg_region_en           = q.bg_region;
   assign o_replacement_policy_bit = q.repl;
   assign o_replace_random         = 1'b1;
   assign o_high_vector_base       = q.high_vec;
   assign o_icache_en              = q.icache;
   assign o_dcache_en              = q.dcache;
   assign o_swap_instr_enable      = q.swap;
   assign o_align_check            = q.align;
   assign o_mpu_en                 = q.mpu;
   assign o_vector_base            = q.high_vec ? csc_pkg::VEC_HIGH_BASE : csc_pkg::VEC_LOW_BASE;
   assign o_irq_vector_addr        = o_vector_base | csc_pkg::VEC_IRQ_OFS;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_reset_n);

   logic rd_ok;
   assign rd_ok = take && i_req.priv && !i_req.write;
   logic wr_ctl;
   logic wr_id;
   assign wr_ctl = take && i_req.priv && i_req.write && i_req.sel == csc_pkg::SEL_SYS_CTL;
   assign wr_id  = take && i_req.priv && i_req.write && (i_req.sel == csc_pkg::SEL_GEOM_ID ||
                   i_req.sel == csc_pkg::SEL_LEVEL_ID || i_req.sel == csc_pkg::SEL_AUX_ID);

   answer_one_cycle_a : assert property (take |=> o_resp_valid)
      else $error("request not answered next cycle");
   user_mode_undef_a : assert property (take && !i_req.priv |=> o_resp_undef && o_rdata == 32'h0)
      else $error("user access not undefined");
   geom_fields_a : assert property (rd_ok && i_req.sel == csc_pkg::SEL_GEOM_ID && q.sel_instr
                                    |=> P_ICACHE_KB == 0 ||
                                    (o_rdata[31:28] == 4'hf && o_rdata[2:0] == 3'h1 &&
                                     o_rdata[12:3] == 10'h3 && o_rdata[27:13] == 15'(P_ICACHE_KB * 8 - 1)))
      else $error("instruction cache geometry wrong");
   select_level_zero_a : assert property (rd_ok && i_req.sel == csc_pkg::SEL_GEOM_SEL
                                          |=> o_rdata[31:1] == 31'h0)
      else $error("select level field not zero");
   aux_id_zero_a : assert property (rd_ok && i_req.sel == csc_pkg::SEL_AUX_ID |=> o_rdata == 32'h0)
      else $error("auxiliary id not zero");
   endian_follows_a : assert property (rd_ok && i_req.sel == csc_pkg::SEL_SYS_CTL
                                       |=> o_rdata[31] == $past(o_instr_endian) &&
                                       o_rdata[27] == $past(o_unmaskable_fast_irq))
      else $error("strapped read-only bits wrong");
   fixed_bits_a : assert property (rd_ok && i_req.sel == csc_pkg::SEL_SYS_CTL
                                   |=> (o_rdata & 32'h34f5_8bf8) == 32'h00e5_0878)
      else $error("fixed control bits wrong");
   div_trap_write_a : assert property (take && i_req.priv && i_req.write && i_req.sel == csc_pkg::SEL_SYS_CTL
                                       |=> o_div_zero_trap == $past(i_req.wdata[19]) &&
                                       o_swap_instr_enable == $past(i_req.wdata[10]))
      else $error("control write not applied");
   irq_vector_a : assert property (o_irq_vector_addr ==
                                   (o_high_vector_base ? 32'hffff_0018 : 32'h0000_0018))
      else $error("irq vector address wrong");
   absent_cache_off_a : assert property ((P_ICACHE_KB != 0 || !o_icache_en) &&
                                         (P_DCACHE_KB != 0 || !o_dcache_en))
      else $error("absent cache enabled");
   no_stray_answer_a : assert property (!take |=> !o_resp_valid)
      else $error("answer without a request");
   priv_read_ok_a : assert property (rd_ok && i_req.sel == csc_pkg::SEL_SYS_CTL |=> !o_resp_undef)
      else $error("privileged read refused");
   user_keeps_state_a : assert property (take && !i_req.priv |=> q.sel_instr == $past(q.sel_instr) &&
                                         o_exc_iset == $past(o_exc_iset) && o_mpu_en == $past(o_mpu_en))
      else $error("user access changed state");
   write_reads_zero_a : assert property (take && i_req.write |=> o_rdata == 32'h0)
      else $error("write answered with data");
   data_geom_fields_a : assert property (rd_ok && i_req.sel == csc_pkg::SEL_GEOM_ID && !q.sel_instr
                                         |=> P_DCACHE_KB == 0 ||
                                         (o_rdata[31:28] == 4'hf && o_rdata[2:0] == 3'h1 &&
                                          o_rdata[12:3] == 10'h3 && o_rdata[27:13] == 15'(P_DCACHE_KB * 8 - 1)))
      else $error("data cache geometry wrong");
   level_fields_a : assert property (rd_ok && i_req.sel == csc_pkg::SEL_LEVEL_ID
                                     |=> o_rdata[31:30] == 2'h0 && o_rdata[26:24] == o_rdata[29:27] &&
                                     o_rdata[29:27] == ((P_ICACHE_KB != 0 || P_DCACHE_KB != 0) ? 3'h1 : 3'h0) &&
                                     o_rdata[23:21] == 3'h0)
      else $error("unification or coherency level wrong");
   outer_levels_zero_a : assert property (rd_ok && i_req.sel == csc_pkg::SEL_LEVEL_ID
                                          |=> o_rdata[20:2] == 19'h0)
      else $error("outer cache levels not zero");
   cache_present_a : assert property (rd_ok && i_req.sel == csc_pkg::SEL_LEVEL_ID
                                      |=> o_rdata[1] == (P_DCACHE_KB != 0) &&
                                      o_rdata[0] == (P_ICACHE_KB != 0))
      else $error("cache presence bits wrong");
   id_write_ignored_a : assert property (wr_id |=> !o_resp_undef && q.sel_instr == $past(q.sel_instr) &&
                                         o_div_zero_trap == $past(o_div_zero_trap))
      else $error("identification write changed state");
   select_write_a : assert property (take && i_req.priv && i_req.write && i_req.sel == csc_pkg::SEL_GEOM_SEL
                                     |=> q.sel_instr == $past(i_req.wdata[0]))
      else $error("cache select bit not stored");
   // the strap copy comes from the second synchroniser stage on the same edge that raises ready
   strap_load_a : assert property ($rose(o_req_ready)
                                   |-> o_exc_iset == $past(q.strap_sync[csc_pkg::STRAP_ISET]) &&
                                   o_exc_endian == $past(q.strap_sync[csc_pkg::STRAP_EENDIAN]) &&
                                   o_high_vector_base == $past(q.strap_sync[csc_pkg::STRAP_HIVEC]))
      else $error("reset value not taken from straps");
   exc_bits_write_a : assert property (wr_ctl |=> o_exc_iset == $past(i_req.wdata[csc_pkg::SC_ISET]) &&
                                       o_exc_endian == $past(i_req.wdata[csc_pkg::SC_EENDIAN]))
      else $error("exception controls not writable");
   vec_write_a : assert property (wr_ctl |=> o_vectored_irq_select == $past(i_req.wdata[csc_pkg::SC_VECIRQ]) &&
                                  o_high_vector_base == $past(i_req.wdata[csc_pkg::SC_HIVEC]))
      else $error("vector controls not written");
   repl_stored_a : assert property (wr_ctl |=> o_replacement_policy_bit == $past(i_req.wdata[csc_pkg::SC_REPL]) &&
                                    o_replace_random)
      else $error("replacement bit or policy wrong");
   cache_enable_a : assert property (wr_ctl
                                     |=> o_icache_en == ($past(i_req.wdata[csc_pkg::SC_ICACHE]) && P_ICACHE_KB != 0) &&
                                     o_dcache_en == ($past(i_req.wdata[csc_pkg::SC_DCACHE]) && P_DCACHE_KB != 0))
      else $error("cache enable write wrong");
   align_mpu_write_a : assert property (wr_ctl |=> o_align_check == $past(i_req.wdata[csc_pkg::SC_ALIGN]) &&
                                        o_mpu_en == ($past(i_req.wdata[csc_pkg::SC_MPU]) && P_HAS_MPU))
      else $error("alignment or protection enable wrong");
   strap_bits_kept_a : assert property (wr_ctl |=> o_instr_endian == $past(q.strap_meta[csc_pkg::STRAP_IENDIAN]) &&
                                        o_unmaskable_fast_irq == $past(q.strap_meta[csc_pkg::STRAP_NMFIQ]))
      else $error("read-only strap bits written");
   vector_base_a : assert property (o_vector_base == (o_high_vector_base ? 32'hffff_0000 : 32'h0000_0000))
      else $error("vector base wrong");

endmodule

/* File: verification/csc_pipe_model.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------
// pipeline side: one privileged or user move at a time
// --------------------------------------------------------------
module csc_pipe_model (
   input  wire logic         i_ref_clk,
   input  wire logic         i_req_ready,
   input  wire logic         i_resp_valid,
   input  wire logic         i_resp_undef,
   input  wire logic [31:0]  i_rdata,
   output csc_pkg::csc_req_s o_req
);
   initial o_req = '0;

   // mode bit
   // request is held until an edge with ready high; idle lines go inverted so stale data never matches
   task automatic move(input logic wr, input logic pv, input csc_pkg::csc_sel_s sel, input logic [31:0] wd,
                       output logic [31:0] rd, output logic undef, output logic answered);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      #1;
      o_req = '{valid: 1'b1, write: wr, priv: pv, sel: sel, wdata: wd};
      while (!i_req_ready && n < 20) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      @(posedge i_ref_clk);
      #1;
      o_req = '{valid: 1'b0, write: ~wr, priv: ~pv, sel: ~sel, wdata: ~wd};
      answered = i_resp_valid;
      rd = i_rdata;
      undef = i_resp_undef;
   endtask
endmodule

/* File: verification/csc_regs_bench.sv */
`timescale 1ns/1ps
module csc_regs_bench;
   localparam csc_pkg::csc_sel_s SC  = csc_pkg::SEL_SYS_CTL;
   localparam csc_pkg::csc_sel_s GS  = csc_pkg::SEL_GEOM_SEL;
   localparam csc_pkg::csc_sel_s GI  = csc_pkg::SEL_GEOM_ID;
   localparam csc_pkg::csc_sel_s LI  = csc_pkg::SEL_LEVEL_ID;
   localparam csc_pkg::csc_sel_s AX  = csc_pkg::SEL_AUX_ID;
   localparam csc_pkg::csc_sel_s BAD = '{opc1: 3'h0, crn: 4'h2, crm: 4'h0, opc2: 3'h0};

   logic              ref_clk;
   logic              reset_n;
   logic              s_ie, s_iset, s_ee, s_nf, s_hv;
   csc_pkg::csc_req_s req;
   logic              ready, rvalid, rundef, rnd;
   logic [31:0]       rdata, vbase, irqa;
   logic [13:0]       ctl;
   int                n_fail = 0;
   int                cmp_count = 0;
   int                cycles = 0;

   // data cache smaller than instruction cache so the select bit is visible
   csc_regs #(.P_ICACHE_KB(16), .P_DCACHE_KB(4), .P_HAS_MPU(1'b1)) DUT (
      .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_req(req), .o_req_ready(ready),
      .o_resp_valid(rvalid), .o_resp_undef(rundef), .o_rdata(rdata),
      .i_instr_endian_strap(s_ie), .i_exc_iset_strap(s_iset), .i_exc_endian_strap(s_ee),
      .i_unmaskable_fast_irq_strap(s_nf), .i_high_vector_strap(s_hv),
      .o_instr_endian(ctl[13]), .o_exc_iset(ctl[12]), .o_exc_endian(ctl[11]),
      .o_unmaskable_fast_irq(ctl[10]), .o_vectored_irq_select(ctl[9]), .o_div_zero_trap(ctl[8]),
      .o_bg_region_en(ctl[7]), .o_replacement_policy_bit(ctl[6]), .o_replace_random(rnd),
      .o_high_vector_base(ctl[5]), .o_icache_en(ctl[4]), .o_swap_instr_enable(ctl[3]),
      .o_dcache_en(ctl[2]), .o_align_check(ctl[1]), .o_mpu_en(ctl[0]),
      .o_vector_base(vbase), .o_irq_vector_addr(irqa));

   csc_pipe_model PIPE (.i_ref_clk(ref_clk), .i_req_ready(ready), .i_resp_valid(rvalid),
      .i_resp_undef(rundef), .i_rdata(rdata), .o_req(req));

   // --------------------------------------------------------------
   // clock, timeout, shared tasks
   // --------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // the whole sequence needs well under 300 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 1500) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic pv, input csc_pkg::csc_sel_s sel, input logic [31:0] wd,
                      input logic [31:0] exp, input logic exp_undef);
      logic [31:0] rd;
      logic        undef;
      logic        ans;
      PIPE.move(wr, pv, sel, wd, rd, undef, ans);
      check({31'h0, ans}, 32'h1);
      check({31'h0, undef}, {31'h0, exp_undef});
      check(rd, exp);
   endtask

   task automatic do_reset();
      @(posedge ref_clk);
      #1;
      reset_n = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
   endtask

   // --------------------------------------------------------------
   // sequence
   // --------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      {s_ie, s_iset, s_ee, s_nf, s_hv} = 5'h1b;
      do_reset();
      acc(1'b0, 1'b1, SC, 32'h0, 32'hc8e52878, 1'b0);
      s_iset = 1'b0;
      s_ee = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      acc(1'b0, 1'b1, SC, 32'h0, 32'hc8e52878, 1'b0);
      check({18'h0, ctl}, 32'h3420);
      check(vbase, 32'hffff0000);
      check(irqa, 32'hffff0018);
      acc(1'b1, 1'b1, SC, 32'hffffffff, 32'h0, 1'b0);
      acc(1'b0, 1'b1, SC, 32'h0, 32'hcbef7c7f, 1'b0);
      check({18'h0, ctl}, 32'h3fff);
      check({31'h0, rnd}, 32'h1);
      acc(1'b1, 1'b1, SC, 32'h0, 32'h0, 1'b0);
      acc(1'b0, 1'b1, SC, 32'h0, 32'h88e50878, 1'b0);
      check({18'h0, ctl}, 32'h2400);
      check(vbase, 32'h0);
      check(irqa, 32'h18);
      acc(1'b0, 1'b0, SC, 32'h0, 32'h0, 1'b1);
      acc(1'b1, 1'b0, SC, 32'hffffffff, 32'h0, 1'b1);
      acc(1'b0, 1'b1, SC, 32'h0, 32'h88e50878, 1'b0);
      acc(1'b1, 1'b1, GS, 32'hf, 32'h0, 1'b0);
      acc(1'b0, 1'b1, GS, 32'h0, 32'h1, 1'b0);
      acc(1'b0, 1'b1, GI, 32'h0, 32'hf00fe019, 1'b0);
      acc(1'b1, 1'b1, GS, 32'h0, 32'h0, 1'b0);
      acc(1'b0, 1'b1, GI, 32'h0, 32'hf003e019, 1'b0);
      acc(1'b0, 1'b0, GI, 32'h0, 32'h0, 1'b1);
      acc(1'b1, 1'b1, GI, 32'hffffffff, 32'h0, 1'b0);
      acc(1'b0, 1'b1, GI, 32'h0, 32'hf003e019, 1'b0);
      acc(1'b0, 1'b1, LI, 32'h0, 32'h09000003, 1'b0);
      acc(1'b1, 1'b1, LI, 32'hffffffff, 32'h0, 1'b0);
      acc(1'b0, 1'b1, LI, 32'h0, 32'h09000003, 1'b0);
      acc(1'b1, 1'b1, AX, 32'hffffffff, 32'h0, 1'b0);
      acc(1'b0, 1'b1, AX, 32'h0, 32'h0, 1'b0);
      acc(1'b0, 1'b1, BAD, 32'h0, 32'h0, 1'b1);
      // read-only strap bits track their pins after reset
      s_ie = 1'b0;
      s_nf = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      acc(1'b0, 1'b1, SC, 32'h0, 32'h00e50878, 1'b0);
      check({18'h0, ctl}, 32'h0);
      // second reset with other strap levels
      s_hv = 1'b0;
      do_reset();
      acc(1'b0, 1'b1, SC, 32'h0, 32'h02e50878, 1'b0);
      check(vbase, 32'h0);
      tally_and_finish();
   end
endmodule
